// ===== rtl/padrst_pkg.sv
// Package for the pad reset/default state controller.
// Assumes a single 25 MHz core clock and an asynchronous active-high reset.
package padrst_pkg;
    localparam int PADRST_DATA_W = 8;
    localparam int PADRST_CLK_MHZ = 25;
    localparam int PADRST_SAMPLE_NS = 200;
    localparam int PADRST_SAMPLE_CYC =
        (PADRST_SAMPLE_NS * PADRST_CLK_MHZ + 999) / 1000;
    localparam int PADRST_SYNC_CYC = 2;
    localparam int PADRST_CNT_W = 8;
    localparam logic [1:0] PADRST_CFG_RESET = 2'h0;
    // JTAG TAP state codes used to find the shift phases
    localparam logic [3:0] PADRST_TAP_RESET = 4'hF;
    localparam logic [3:0] PADRST_TAP_SHIFT_DR = 4'h2;
    localparam logic [3:0] PADRST_TAP_SHIFT_IR = 4'hA;
    typedef enum logic [2:0]
    {
        PADRST_ST_IDLE = 3'b000,
        PADRST_ST_POWER = 3'b001,
        PADRST_ST_SAMPLE = 3'b010,
        PADRST_ST_DONE = 3'b011
    } padrst_state_e;
endpackage

// ===== rtl/padrst_tap_if.sv
// Interface carrying TAP state between the top and the TAP tracker.
// Assumes both ends run on the core clock.
`timescale 1ns/100ps
interface padrst_tap_if;
    logic tms;
    logic tck_rise;
    logic shift_phase;
    modport tracker (input tms, input tck_rise, output shift_phase);
    modport user (output tms, output tck_rise, input shift_phase);
endinterface

// ===== rtl/padrst_tap.sv
// TAP state follower that flags the data and instruction shift phases.
// Assumes TMS and a TCK rising-edge strobe already synchronised to the core clock.
`timescale 1ns/100ps
module padrst_tap
    import padrst_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    padrst_tap_if.tracker tap
);
    logic [3:0] st_reg;
    logic [3:0] st_next;

    // Next TAP state, standard sixteen-state walk
    always_comb
    begin
        st_next = st_reg;
        if (tap.tck_rise)
        begin
            case (st_reg)
                4'hF: st_next = tap.tms ? 4'hF : 4'hC;
                4'hC: st_next = tap.tms ? 4'h7 : 4'hC;
                4'h7: st_next = tap.tms ? 4'h4 : 4'h6;
                4'h6: st_next = tap.tms ? 4'h1 : 4'h2;
                4'h2: st_next = tap.tms ? 4'h1 : 4'h2;
                4'h1: st_next = tap.tms ? 4'h5 : 4'h3;
                4'h3: st_next = tap.tms ? 4'h0 : 4'h3;
                4'h0: st_next = tap.tms ? 4'h5 : 4'h2;
                4'h5: st_next = tap.tms ? 4'h7 : 4'hC;
                4'h4: st_next = tap.tms ? 4'hF : 4'hE;
                4'hE: st_next = tap.tms ? 4'h9 : 4'hA;
                4'hA: st_next = tap.tms ? 4'h9 : 4'hA;
                4'h9: st_next = tap.tms ? 4'hD : 4'hB;
                4'hB: st_next = tap.tms ? 4'h8 : 4'hB;
                4'h8: st_next = tap.tms ? 4'hD : 4'hA;
                4'hD: st_next = tap.tms ? 4'h7 : 4'hC;
                default: st_next = PADRST_TAP_RESET;
            endcase
        end
    end

    // State register
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            st_reg <= PADRST_TAP_RESET;
        else
            st_reg <= st_next;
    end

    // Output only in the two shift states
    assign tap.shift_phase = (st_reg == PADRST_TAP_SHIFT_DR) ||
                             (st_reg == PADRST_TAP_SHIFT_IR);

    a_tap_reset_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
        (st_reg == PADRST_TAP_RESET) |-> !tap.shift_phase)
        else $error("shift flagged in test logic reset");
endmodule

// ===== rtl/padrst_top.sv
// Pad reset/default state controller for video, analog video and test pins.
// Assumes pads resolve levels from the enables; pins arrive asynchronously.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// - Video pads high-Z in reset and while the interface is disabled, then driven
// - Low data pad input buffers normally powered down
// - After reset power, sample, repower-down low pads
// - Analog video off in reset, on streaming
// - TDO high-Z except in shift phases
// - Pull-ups always on TDI, TMS, TCK
// - Unpowered, undriven pads draw nothing, drive nothing
module padrst_top
    import padrst_pkg::*;
#(
    parameter int DATA_W = PADRST_DATA_W,
    parameter int SAMPLE_CYC = PADRST_SAMPLE_CYC
)
(
    input wire logic I_CLK,
    input wire logic I_RST,
    input wire logic i_IF_ENABLE,
    input wire logic i_STREAMING,
    input wire logic [DATA_W-1:0] i_VIDEO_DATA,
    input wire logic i_PIXEL_CLOCK,
    input wire logic i_EXTRA_LOW_DATA_BIT_ZERO,
    input wire logic i_EXTRA_LOW_DATA_BIT_ONE,
    input wire logic i_TCK,
    input wire logic i_TMS,
    input wire logic i_TDO_DATA,
    output logic [DATA_W-1:0] o_VIDEO_DATA_OUT,
    output logic [DATA_W-1:0] o_VIDEO_DATA_OE,
    output logic o_PIXEL_CLOCK_OUT,
    output logic o_PIXEL_CLOCK_OE,
    output logic o_EXTRA_LOW_DATA_BIT_ZERO,
    output logic o_EXTRA_LOW_DATA_BIT_ZERO_OE,
    output logic o_EXTRA_LOW_DATA_BIT_ONE_OE,
    output logic o_LOW_PAD_IBUF_EN,
    output logic [1:0] o_AUTO_CFG,
    output logic o_AUTO_CFG_VALID,
    output logic o_ANALOG_VIDEO_EN,
    output logic o_TDO,
    output logic o_TDO_OE,
    output logic o_TDI_PULLUP,
    output logic o_TMS_PULLUP,
    output logic o_TCK_PULLUP
);
    // Elaboration check: the counter must hold the sample length
    if (DATA_W < 1 || SAMPLE_CYC < PADRST_SYNC_CYC + 1 ||
        SAMPLE_CYC >= (1 << PADRST_CNT_W))
    begin
        $error("padrst_top: parameter out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: first stage read only by the second
    logic [1:0] lp_s1_reg;
    logic [1:0] lp_s2_reg;
    logic [2:0] jt_s1_reg;
    logic [2:0] jt_s2_reg;
    logic tck_old_reg;

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            lp_s1_reg <= 2'h0;
            lp_s2_reg <= 2'h0;
            // TCK and TMS idle high on their pull-ups; avoids a false TCK edge
            jt_s1_reg <= 3'h6;
            jt_s2_reg <= 3'h6;
            tck_old_reg <= 1'b1;
        end
        else
        begin
            lp_s1_reg <= {i_EXTRA_LOW_DATA_BIT_ONE, i_EXTRA_LOW_DATA_BIT_ZERO};
            lp_s2_reg <= lp_s1_reg;
            jt_s1_reg <= {i_TCK, i_TMS, i_TDO_DATA};
            jt_s2_reg <= jt_s1_reg;
            tck_old_reg <= jt_s2_reg[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Auto-configuration sampling sequence after reset release
    padrst_state_e st_reg;
    padrst_state_e st_next;
    logic [PADRST_CNT_W-1:0] cnt_reg;
    logic [PADRST_CNT_W-1:0] cnt_next;
    logic [1:0] cfg_reg;
    logic [1:0] cfg_next;
    logic cfg_valid_reg;
    logic cfg_valid_next;

    // Buffers are powered long enough for the synchroniser to settle
    always_comb
    begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        cfg_next = cfg_reg;
        cfg_valid_next = cfg_valid_reg;
        case (st_reg)
            PADRST_ST_IDLE:
            begin
                st_next = PADRST_ST_POWER;
                cnt_next = '0;
            end
            PADRST_ST_POWER:
            begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg == PADRST_CNT_W'(SAMPLE_CYC - 1))
                    st_next = PADRST_ST_SAMPLE;
            end
            PADRST_ST_SAMPLE:
            begin
                cfg_next = lp_s2_reg;
                cfg_valid_next = 1'b1;
                st_next = PADRST_ST_DONE;
            end
            PADRST_ST_DONE:
                st_next = PADRST_ST_DONE;
            default:
                st_next = PADRST_ST_IDLE;
        endcase
    end

    // Sequence registers
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            st_reg <= PADRST_ST_IDLE;
            cnt_reg <= '0;
            cfg_reg <= PADRST_CFG_RESET;
            cfg_valid_reg <= 1'b0;
        end
        else
        begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            cfg_reg <= cfg_next;
            cfg_valid_reg <= cfg_valid_next;
        end
    end

    // Buffers only up while sampling; otherwise off so floating is safe
    assign o_LOW_PAD_IBUF_EN = (st_reg == PADRST_ST_POWER) || (st_reg == PADRST_ST_SAMPLE);
    assign o_AUTO_CFG = cfg_reg;
    assign o_AUTO_CFG_VALID = cfg_valid_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Video and analog enables; the enable input is same-domain logic
    logic if_en_reg;
    logic if_en_next;
    logic dac_en_reg;
    logic dac_en_next;
    logic [DATA_W-1:0] vdat_reg;
    logic [DATA_W-1:0] vdat_next;
    logic pclk_reg;
    logic pclk_next;
    logic lsb0_reg;
    logic lsb0_next;

    // Single enable; data forced low until the interface enable is set
    always_comb
    begin
        if_en_next = i_IF_ENABLE;
        dac_en_next = i_STREAMING;
        vdat_next = if_en_next ? i_VIDEO_DATA : '0;
        pclk_next = if_en_next ? i_PIXEL_CLOCK : 1'b0;
        lsb0_next = 1'b0;
    end

    // Output flops, cleared by reset
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            if_en_reg <= 1'b0;
            dac_en_reg <= 1'b0;
            vdat_reg <= '0;
            pclk_reg <= 1'b0;
            lsb0_reg <= 1'b0;
        end
        else
        begin
            if_en_reg <= if_en_next;
            dac_en_reg <= dac_en_next;
            vdat_reg <= vdat_next;
            pclk_reg <= pclk_next;
            lsb0_reg <= lsb0_next;
        end
    end

    // Reset forces high-Z combinationally, independent of the flop
    assign o_VIDEO_DATA_OE = {DATA_W{if_en_reg & ~I_RST}};
    assign o_PIXEL_CLOCK_OE = if_en_reg & ~I_RST;
    assign o_VIDEO_DATA_OUT = vdat_reg;
    assign o_PIXEL_CLOCK_OUT = pclk_reg;
    assign o_EXTRA_LOW_DATA_BIT_ZERO = lsb0_reg;
    // Bit zero drives low once sampled and while the interface is enabled, never in reset
    assign o_EXTRA_LOW_DATA_BIT_ZERO_OE = cfg_valid_reg & if_en_reg & ~I_RST;
    assign o_EXTRA_LOW_DATA_BIT_ONE_OE = 1'b0; // Stays high-Z
    assign o_ANALOG_VIDEO_EN = dac_en_reg & ~I_RST;

    ////////////////////////////////////////////////////////////////////////////
    // Test port: TAP follower, pull-ups; TRST and sync pins are board-tied
    padrst_tap_if tap_bus ();
    logic tdo_reg;
    logic tdo_next;

    assign tap_bus.tms = jt_s2_reg[1];
    assign tap_bus.tck_rise = jt_s2_reg[2] & ~tck_old_reg;

    padrst_tap u_tap (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .tap(tap_bus)
    );

    // Data out latched each cycle
    always_comb
    begin
        tdo_next = jt_s2_reg[0];
    end

    // Registered test data
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            tdo_reg <= 1'b0;
        else
            tdo_reg <= tdo_next;
    end

    assign o_TDO = tdo_reg;
    assign o_TDO_OE = tap_bus.shift_phase & ~I_RST;
    assign o_TDI_PULLUP = 1'b1;
    assign o_TMS_PULLUP = 1'b1;
    assign o_TCK_PULLUP = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_video_follows_en: assert property (@(posedge I_CLK) disable iff (I_RST)
        !if_en_reg |-> (o_VIDEO_DATA_OE == '0) && (o_VIDEO_DATA_OUT == '0))
        else $error("video pads driven while interface disabled");
    a_ibuf_off_done: assert property (@(posedge I_CLK) disable iff (I_RST)
        (st_reg == PADRST_ST_DONE) |-> !o_LOW_PAD_IBUF_EN)
        else $error("low pad buffers powered after sampling");
    a_sample_seq: assert property (@(posedge I_CLK) disable iff (I_RST)
        $rose(o_AUTO_CFG_VALID) |-> $past(o_LOW_PAD_IBUF_EN) && !o_LOW_PAD_IBUF_EN)
        else $error("config captured outside power window");
    a_cfg_latency: assert property (@(posedge I_CLK) disable iff (I_RST)
        $rose(o_LOW_PAD_IBUF_EN) |-> o_LOW_PAD_IBUF_EN [*3] ##[1:300] o_AUTO_CFG_VALID)
        else $error("config sample not taken in time");
    a_dac_stream: assert property (@(posedge I_CLK) disable iff (I_RST)
        i_STREAMING |=> o_ANALOG_VIDEO_EN)
        else $error("analog video not enabled on streaming");
    a_tdo_shift_only: assert property (@(posedge I_CLK) disable iff (I_RST)
        o_TDO_OE |-> tap_bus.shift_phase)
        else $error("tdo driven outside shift");
    a_pullups_on: assert property (@(posedge I_CLK) disable iff (I_RST)
        o_TDI_PULLUP && o_TMS_PULLUP && o_TCK_PULLUP)
        else $error("pull-up dropped");
    a_lsb1_hiz: assert property (@(posedge I_CLK) disable iff (I_RST)
        !o_EXTRA_LOW_DATA_BIT_ONE_OE && (cfg_valid_reg || !o_EXTRA_LOW_DATA_BIT_ZERO_OE))
        else $error("low pad driven while sampling or reserved");
    a_single_enable: assert property (@(posedge I_CLK) disable iff (I_RST)
        o_PIXEL_CLOCK_OE == o_VIDEO_DATA_OE[0])
        else $error("video enables disagree");
endmodule

// ===== testbench/padrst_board.sv
// Board model: pad straps, JTAG pins resolved with device pull-ups, test ties.
// Assumes the bench changes driven levels just after core clock rising edges.
`timescale 1ns/100ps
module padrst_board
(
    input wire logic i_float,
    input wire logic i_tck_drv,
    input wire logic i_tms_drv,
    input wire logic i_tck_pullup,
    input wire logic i_tms_pullup,
    input wire logic [1:0] i_strap,
    output logic o_tck,
    output logic o_tms,
    output logic [1:0] o_pad,
    output logic [3:0] o_ties
);
    logic trst_n_tie;
    logic frame_sync_tie;
    logic [1:0] atest_tie;
    // Open pins settle only through the device pull-ups; no pull-up reads low
    assign o_tck = i_float ? i_tck_pullup : i_tck_drv;
    assign o_tms = i_float ? i_tms_pullup : i_tms_drv;
    // Test and sync inputs are strapped to ground, never left open
    assign trst_n_tie = 1'b0;
    assign frame_sync_tie = 1'b0;
    assign atest_tie = 2'h0;
    // Ties are shown to the bench so it can see they stay grounded
    assign o_ties = {trst_n_tie, frame_sync_tie, atest_tie};
    // Straps hold a firm level; they matter only while the buffers sample
    assign o_pad = i_strap;
endmodule

// ===== testbench/tb_padrst_top.sv
// Self-checking bench for the pad reset/default state controller.
// Assumes the default sample length and a 25 MHz core clock.
`timescale 1ns/100ps
module tb_padrst_top;
    import padrst_pkg::*;
    localparam int SC = 5;
    logic clk = 0;
    logic rst = 1;
    logic en = 0;
    logic strm = 0;
    logic [7:0] din = 8'h00;
    logic pclk = 0;
    logic tdo_d = 0;
    logic flt = 1;
    logic tck = 1;
    logic tms = 1;
    logic [1:0] strap = 2'h2;
    logic ptck, ptms;
    logic [1:0] pad;
    logic [3:0] ties;
    logic [7:0] dout, doe;
    logic pco, pcoe, b0, b0oe, b1oe, ibuf, cfgv, aen, tdo, tdooe, pu_i, pu_m, pu_c;
    logic [1:0] cfg;
    int fail_count = 0;
    int samples_checked = 0;
    padrst_board u_padrst_board (.i_float(flt), .i_tck_drv(tck), .i_tms_drv(tms),
        .i_tck_pullup(pu_c), .i_tms_pullup(pu_m), .i_strap(strap), .o_tck(ptck),
        .o_tms(ptms), .o_pad(pad), .o_ties(ties));
    padrst_top #(.SAMPLE_CYC(SC)) u_padrst_top (.I_CLK(clk), .I_RST(rst),
        .i_IF_ENABLE(en), .i_STREAMING(strm), .i_VIDEO_DATA(din), .i_PIXEL_CLOCK(pclk),
        .i_EXTRA_LOW_DATA_BIT_ZERO(pad[0]), .i_EXTRA_LOW_DATA_BIT_ONE(pad[1]),
        .i_TCK(ptck), .i_TMS(ptms), .i_TDO_DATA(tdo_d), .o_VIDEO_DATA_OUT(dout),
        .o_VIDEO_DATA_OE(doe), .o_PIXEL_CLOCK_OUT(pco), .o_PIXEL_CLOCK_OE(pcoe),
        .o_EXTRA_LOW_DATA_BIT_ZERO(b0), .o_EXTRA_LOW_DATA_BIT_ZERO_OE(b0oe),
        .o_EXTRA_LOW_DATA_BIT_ONE_OE(b1oe), .o_LOW_PAD_IBUF_EN(ibuf), .o_AUTO_CFG(cfg),
        .o_AUTO_CFG_VALID(cfgv), .o_ANALOG_VIDEO_EN(aen), .o_TDO(tdo), .o_TDO_OE(tdooe),
        .o_TDI_PULLUP(pu_i), .o_TMS_PULLUP(pu_m), .o_TCK_PULLUP(pu_c));
    ////////////////////////////////////////
    // Clock, 40 ns period
    always #20 clk = ~clk;
    // Compare one value and count it
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Everything parked while reset is held
    task chk_reset_state();
        chk("video_oe", doe, 8'h00);
        chk("pclk_oe", pcoe, 8'h00);
        chk("low_oe", {b1oe, b0oe}, 8'h00);
        chk("ibuf", ibuf, 8'h00);
        chk("analog", aen, 8'h00);
        chk("tdo_oe", tdooe, 8'h00);
        chk("pullups", {pu_i, pu_m, pu_c}, 8'h07);
    endtask
    // Release reset, count buffer power-up cycles, then check the sample
    task release_cfg(input logic [1:0] s);
        int n;
        n = 0;
        @(posedge clk);
        strap <= s;
        rst <= 0;
        for (int i = 0; i < 20 && cfgv !== 1'b1; i++)
        begin
            step(1);
            if (ibuf === 1'b1)
                n++;
        end
        chk("ibuf_cycles", 8'(n), 8'(SC + 1));
        chk("cfg", {cfgv, cfg}, {5'h00, 1'b1, s});
        @(posedge clk);
        strap <= ~s;
        step(4);
        chk("cfg_hold", {ibuf, cfg}, {6'h00, s});
    endtask
    // Interface enable drives all video pads together
    task t_enable();
        @(posedge clk);
        en <= 1;
        din <= 8'hA5;
        pclk <= 1;
        step(2);
        chk("video_oe", doe, 8'hFF);
        chk("video", dout, 8'hA5);
        chk("pclk", {pcoe, pco}, 8'h03);
        chk("low_pads", {b1oe, b0oe, b0}, 8'h02);
        @(posedge clk);
        din <= 8'h00;
        pclk <= 0;
        step(2);
        chk("video_low", {pco, dout}, 8'h00);
        @(posedge clk);
        en <= 0;
        step(2);
        chk("video_off", {pcoe, doe[6:0]}, 8'h00);
    endtask
    // Streaming turns analog video on; reset in mid-run drops everything
    task t_analog();
        @(posedge clk);
        strm <= 1;
        en <= 1;
        step(2);
        chk("analog_on", aen, 8'h01);
        @(posedge clk);
        rst <= 1;
        step(1);
        chk_reset_state();
        release_cfg(2'h1);
        chk("analog_stream", aen, 8'h01);
        @(posedge clk);
        strm <= 0;
        en <= 0;
        step(2);
        chk("analog_off", aen, 8'h00);
    endtask
    // One test clock period, TCK low four core cycles, then high six or more
    task tck_cyc(input logic m);
        @(posedge clk);
        tms <= m;
        tck <= 0;
        repeat (4) @(posedge clk);
        tck <= 1;
        step(6);
    endtask
    // Walk to the data shift phase and out again
    task t_tap();
        @(posedge clk);
        flt <= 0;
        tdo_d <= 1;
        tck_cyc(0);
        tck_cyc(1);
        tck_cyc(0);
        chk("tdo_oe_cap", tdooe, 8'h00);
        tck_cyc(0);
        chk("tdo_shift", {tdooe, tdo}, 8'h03);
        tck_cyc(1);
        chk("tdo_exit", tdooe, 8'h00);
    endtask
    task final_report();
        $display("Checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////
    // Main sequence
    initial
    begin
        step(2);
        chk_reset_state();
        release_cfg(2'h2);
        chk("tdo_idle", tdooe, 8'h00);
        chk("board_ties", ties, 8'h00);
        t_enable();
        t_analog();
        t_tap();
        final_report();
    end
    // Watchdog against a hang
    initial
    begin
        repeat (3000) @(posedge clk);
        fail_count++;
        final_report();
    end
endmodule
